/* File: hdl/vtg_core.sv */
// Video timing generator: line/field counters, master/slave timing, blanking, burst.
// Assumes a classic Wishbone master, synchronous pins and one pixel clock.
//
// Register access over Wishbone and the address map were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
module vtg_core (
	// Clock and reset.
	input wire logic clk_i,
	input wire logic rst_i,
	// Wishbone slave.
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [7:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	output logic [31:0] dat_o,
	output logic ack_o,
	// Timing pins.
	input wire vtg_pkg::vtg_pins_t pins_i,
	output vtg_pkg::vtg_pins_t pins_o,
	output vtg_pkg::vtg_pins_t pins_oe_o,
	// Pixel stream.
	input wire logic [7:0] pixel_bus_low_i,
	output logic [7:0] pixel_o,
	output vtg_pkg::vtg_line_t line_o,
	output logic [9:0] line_num_o,
	output logic field_o
);
	import vtg_pkg::*;

	// ************************************************************
	// Helpers
	// ************************************************************
	function automatic logic in_rng(input logic [9:0] v, input int lo, input int hi);
		in_rng = (v >= 10'(lo)) && (v <= 10'(hi));
	endfunction

	function automatic logic vbi_open_f(input logic [9:0] v, input logic is625,
		input logic half2);
		if (is625) begin
			vbi_open_f = in_rng(v, 7, 22) || in_rng(v, 319, 335);
		end else begin
			vbi_open_f = in_rng(v, 10, 21) || in_rng(v, 274, 284) || (v == 10'd273 && half2);
		end
	endfunction

	// ************************************************************
	// Registers
	// ************************************************************
	logic [7:0] mode0_r;
	logic [7:0] mode3_r;
	logic [7:0] timing0_r;
	logic [31:0] subcar_r;
	logic ack_r;
	logic [31:0] dat_r;
	logic bus_req;
	logic is625;
	vtg_mode_t mode;

	assign bus_req = cyc_i && stb_i && !ack_r;
	assign is625 = mode0_r[MODE0_STD_LO];
	assign mode = vtg_mode_t'(timing0_r[2:0]);

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			mode0_r <= MODE0_RST;
			mode3_r <= REG_RST;
			timing0_r <= REG_RST;
			subcar_r <= SUBCAR_RST;
		end else if (bus_req && we_i) begin
			case (adr_i)
				ADR_MODE0: if (sel_i[0]) mode0_r <= dat_i[7:0];
				ADR_MODE3: if (sel_i[0]) mode3_r <= dat_i[7:0];
				ADR_TIMING0: if (sel_i[0]) timing0_r <= dat_i[7:0];
				ADR_SUBCAR: begin
					for (int b = 0; b < 4; b++) begin
						if (sel_i[b]) subcar_r[8*b +: 8] <= dat_i[8*b +: 8];
					end
				end
				default: begin
				end
			endcase
		end
	end

	// ************************************************************
	// Counters
	// ************************************************************
	logic [10:0] pix_r;
	logic [9:0] line_r;
	logic field_r;
	logic [2:0] fseq_r;
	logic [9:0] lines_max;
	logic [31:0] code_sr_r;
	logic hs_d_r;
	logic vf_d_r;
	logic line_start;
	logic frame_start;
	logic even_start;
	logic master;

	assign lines_max = is625 ? LINES_625 : LINES_525;
	assign master = timing0_r[0];

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			hs_d_r <= 1'b1;
			vf_d_r <= 1'b1;
			code_sr_r <= 32'h00000000;
		end else begin
			hs_d_r <= pins_i.hsync_n;
			vf_d_r <= pins_i.vsync_field;
			code_sr_r <= {code_sr_r[23:0], pixel_bus_low_i};
		end
	end

	always_comb begin
		line_start = 1'b0;
		frame_start = 1'b0;
		even_start = 1'b0;
		case (mode)
			VTG_EMB_SLAVE: begin
				line_start = code_sr_r[31:8] == 24'hff0000 && code_sr_r[7:0] == EAV_CODE;
				frame_start = line_start && (line_r == lines_max);
			end
			VTG_HF_SLAVE: begin
				line_start = hs_d_r && !pins_i.hsync_n;
				frame_start = (vf_d_r != pins_i.vsync_field) && !pins_i.hsync_n;
			end
			VTG_HV_SLAVE: begin
				line_start = hs_d_r && !pins_i.hsync_n;
				frame_start = vf_d_r && !pins_i.vsync_field && line_start;
				even_start = vf_d_r && !pins_i.vsync_field && pins_i.hsync_n;
			end
			VTG_HF3_SLAVE: begin
				line_start = hs_d_r && !pins_i.hsync_n;
				frame_start = (vf_d_r != pins_i.vsync_field) && pins_i.hsync_n;
			end
			default: begin
				line_start = 1'b0;
				frame_start = 1'b0;
				even_start = 1'b0;
			end
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pix_r <= 11'h000;
			line_r <= 10'h001;
			field_r <= 1'b0;
			fseq_r <= 3'h0;
		end else if (!master && frame_start) begin
			pix_r <= 11'h000;
			line_r <= 10'h001;
			field_r <= 1'b0;
			fseq_r <= fseq_r + 3'h1;
		end else if (!master && even_start) begin
			pix_r <= 11'h000;
			line_r <= is625 ? 10'd313 : 10'd264;
			field_r <= 1'b1;
		end else if (!master && line_start) begin
			pix_r <= 11'h000;
			line_r <= (line_r >= lines_max) ? 10'h001 : line_r + 10'h001;
		end else if (pix_r == PIX_PER_LINE - 11'h001) begin
			pix_r <= 11'h000;
			if (line_r >= lines_max) begin
				line_r <= 10'h001;
				field_r <= 1'b0;
				fseq_r <= fseq_r + 3'h1;
			end else begin
				line_r <= line_r + 10'h001;
				if (line_r == (is625 ? 10'd312 : 10'd262)) begin
					field_r <= 1'b1;
					fseq_r <= fseq_r + 3'h1;
				end
			end
		end else begin
			pix_r <= pix_r + 11'h001;
		end
	end

	// ************************************************************
	// Line classification
	// ************************************************************
	vtg_line_t cls;
	logic prog;
	logic grp_b;
	logic half2;

	assign prog = mode3_r[MODE3_NONINTERLACE];
	assign grp_b = fseq_r[1];
	assign half2 = pix_r >= (PIX_PER_LINE >> 1);

	always_comb begin
		cls = '0;
		if (!is625 && !prog) begin
			cls.vsync = in_rng(line_r, 1, 9) || in_rng(line_r, 264, 272);
			cls.blank = cls.vsync || line_r == 10'd525 || in_rng(line_r, 10, 21) ||
				in_rng(line_r, 262, 263) || in_rng(line_r, 273, 284);
			cls.burst_off = in_rng(line_r, 1, 6) || in_rng(line_r, 261, 269) ||
				in_rng(line_r, 523, 525);
		end else if (!is625) begin
			cls.vsync = in_rng(line_r, 1, 9);
			cls.blank = in_rng(line_r, 1, 21);
			cls.burst_off = in_rng(line_r, 1, 6) || in_rng(line_r, 261, 262);
		end else if (!prog) begin
			cls.vsync = grp_b ?
				(in_rng(line_r, 1, 5) || in_rng(line_r, 311, 319) || in_rng(line_r, 624, 625)) :
				(in_rng(line_r, 1, 6) || in_rng(line_r, 311, 318) ||
				in_rng(line_r, 624, 625));
			cls.blank = cls.vsync || in_rng(line_r, 1, 22) || in_rng(line_r, 311, 335);
			cls.burst_off = grp_b ?
				(in_rng(line_r, 1, 5) || in_rng(line_r, 311, 319) || in_rng(line_r, 623, 625)) :
				(in_rng(line_r, 1, 6) || in_rng(line_r, 311, 318) ||
				in_rng(line_r, 623, 625));
		end else begin
			cls.vsync = in_rng(line_r, 1, 6) || in_rng(line_r, 311, 312);
			cls.blank = cls.vsync || in_rng(line_r, 1, 22) || in_rng(line_r, 311, 312);
			cls.burst_off = in_rng(line_r, 1, 5) || in_rng(line_r, 310, 312);
		end
		cls.vbi_open = cls.blank && !cls.vsync && vbi_open_f(line_r, is625, half2);
	end

	// ************************************************************
	// Outputs
	// ************************************************************
	logic pin_blank;
	logic use_pin_blank;
	logic pass_pixel;
	logic h_bit;

	assign use_pin_blank = mode3_r[MODE3_PIN_BLANK_EN] && !master && mode != VTG_EMB_SLAVE;
	assign pin_blank = use_pin_blank && !pins_i.blank_n;
	assign h_bit = pix_r < ACTIVE_START;
	assign pass_pixel = !h_bit && !pin_blank &&
		(!cls.blank || (cls.vbi_open && mode3_r[MODE3_VBI_PARTIAL]));

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pins_o <= '1;
			pins_oe_o <= '0;
		end else begin
			pins_oe_o <= master ? 3'b111 : 3'b000;
			case (mode)
				VTG_EMB_MASTER: begin
					pins_o.hsync_n <= h_bit;
					pins_o.blank_n <= cls.blank;
					pins_o.vsync_field <= field_r;
				end
				VTG_HV_MASTER: begin
					pins_o.hsync_n <= pix_r >= HSYNC_PIX;
					pins_o.vsync_field <= !(cls.vsync && (line_r != 10'd264 || half2));
					pins_o.blank_n <= !(cls.blank || h_bit);
				end
				VTG_HF_MASTER, VTG_HF3_MASTER: begin
					pins_o.hsync_n <= pix_r >= HSYNC_PIX;
					pins_o.vsync_field <= field_r;
					pins_o.blank_n <= !(cls.blank || h_bit);
				end
				default: begin
					pins_o <= '1;
				end
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pixel_o <= 8'h00;
			line_o <= '0;
			line_num_o <= 10'h001;
			field_o <= 1'b0;
		end else begin
			pixel_o <= pass_pixel ? pixel_bus_low_i : 8'h00;
			line_o <= cls;
			line_num_o <= line_r;
			field_o <= field_r;
		end
	end

	// ************************************************************
	// Bus answer
	// ************************************************************
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_r <= 1'b0;
			dat_r <= 32'h00000000;
		end else begin
			ack_r <= bus_req;
			if (bus_req && !we_i) begin
				case (adr_i)
					ADR_MODE0: dat_r <= {24'h000000, mode0_r};
					ADR_MODE3: dat_r <= {24'h000000, mode3_r};
					ADR_TIMING0: dat_r <= {24'h000000, timing0_r};
					ADR_SUBCAR: dat_r <= subcar_r;
					ADR_STATUS: dat_r <= {9'h000, fseq_r, 9'h000, field_r, line_r};
					default: dat_r <= 32'h00000000;
				endcase
			end
		end
	end

	assign ack_o = ack_r;
	assign dat_o = dat_r;
endmodule
`default_nettype wire

/* File: hdl/vtg_pkg.sv */
// Package for the video timing generator: register map, fields, resets and line figures.
// Assumes a 10 MHz clock and a classic Wishbone slave with 32-bit data.
package vtg_pkg;
	// ************************************************************
	// Register map (byte addresses)
	// ************************************************************
	localparam logic [7:0] ADR_MODE0 = 8'h00;
	localparam logic [7:0] ADR_MODE3 = 8'h04;
	localparam logic [7:0] ADR_TIMING0 = 8'h08;
	localparam logic [7:0] ADR_SUBCAR = 8'h0c;
	localparam logic [7:0] ADR_STATUS = 8'h10;
	// ************************************************************
	// Fields and reset values
	// ************************************************************
	localparam int MODE0_STD_LO = 0;
	localparam int MODE0_STD_HI = 1;
	localparam int MODE0_PEDESTAL = 2;
	localparam int MODE3_VBI_PARTIAL = 1;
	localparam int MODE3_NONINTERLACE = 2;
	localparam int MODE3_PIN_BLANK_EN = 3;
	localparam logic [7:0] MODE0_RST = 8'h04;
	localparam logic [7:0] REG_RST = 8'h00;
	localparam logic [31:0] SUBCAR_RST = 32'h21f07c16;
	localparam logic [1:0] STD_525 = 2'h0;
	// ************************************************************
	// Timing modes
	// ************************************************************
	typedef enum logic [2:0] {
		VTG_EMB_SLAVE = 3'h0,
		VTG_EMB_MASTER = 3'h1,
		VTG_HF_SLAVE = 3'h2,
		VTG_HF_MASTER = 3'h3,
		VTG_HV_SLAVE = 3'h4,
		VTG_HV_MASTER = 3'h5,
		VTG_HF3_SLAVE = 3'h6,
		VTG_HF3_MASTER = 3'h7
	} vtg_mode_t;
	// ************************************************************
	// Line geometry
	// ************************************************************
	localparam logic [9:0] LINES_525 = 10'h20d;
	localparam logic [9:0] LINES_625 = 10'h271;
	localparam logic [10:0] PIX_PER_LINE = 11'h06b;
	localparam logic [10:0] HSYNC_PIX = 11'h008;
	localparam logic [10:0] ACTIVE_START = 11'h014;
	localparam logic [7:0] SAV_CODE = 8'h80;
	localparam logic [7:0] EAV_CODE = 8'h9d;
	// ************************************************************
	// Carriers
	// ************************************************************
	typedef struct packed {
		logic blank;
		logic vsync;
		logic burst_off;
		logic vbi_open;
	} vtg_line_t;
	typedef struct packed {
		logic hsync_n;
		logic vsync_field;
		logic blank_n;
	} vtg_pins_t;
endpackage

/* File: tb/vtg_core_properties.sv */
// Concurrent checks on the ports of the video timing generator.
// Assumes vtg_pkg is compiled first; bound to vtg_core below.
`timescale 1ns/10ps
`default_nettype none
module vtg_core_properties (
	// Clock, reset and bus.
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic ack_o,
	// Video outputs.
	input wire vtg_pkg::vtg_pins_t pins_oe_o,
	input wire logic [7:0] pixel_o,
	input wire vtg_pkg::vtg_line_t line_o,
	input wire logic [9:0] line_num_o,
	input wire logic field_o
);
	import vtg_pkg::*;
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	a_bus_answer: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
		else $error("bus request not answered");
	a_ack_pulse: assert property (ack_o |=> !ack_o)
		else $error("ack longer than one cycle");
	a_reset_state: assert property (disable iff (1'b0) rst_i |=> pins_oe_o == 3'h0
		&& line_num_o == 10'h001 && !field_o && pixel_o == 8'h00)
		else $error("bad state after reset");
	a_oe_group: assert property (pins_oe_o == 3'h0 || pins_oe_o == 3'h7)
		else $error("pin enables split");
	a_line_range: assert property (line_num_o >= 10'h001 && line_num_o <= 10'h271)
		else $error("line number out of range");
	a_line_step: assert property ($changed(line_num_o) |->
		line_num_o == $past(line_num_o) + 10'h001 || line_num_o == 10'h001 ||
		line_num_o == 10'd264 || line_num_o == 10'd313)
		else $error("line number jumped");
	a_sync_blank: assert property (line_o.vsync |-> line_o.blank)
		else $error("sync line not blanked");
	a_sync_dark: assert property (line_o.vsync |-> pixel_o == 8'h00)
		else $error("pixel passed on sync line");
	a_open_nosync: assert property (line_o.vbi_open |-> !line_o.vsync &&
		((line_num_o >= 10'd7 && line_num_o <= 10'd22) ||
		(line_num_o >= 10'd273 && line_num_o <= 10'd284) ||
		(line_num_o >= 10'd319 && line_num_o <= 10'd335)))
		else $error("open line outside data pass-through lines");
	c_ack: cover property (ack_o);
	c_sync: cover property (line_o.vsync);
	c_master: cover property (pins_oe_o == 3'h7);
endmodule
bind vtg_core vtg_core_properties u_props (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
	.stb_i(stb_i), .ack_o(ack_o), .pins_oe_o(pins_oe_o), .pixel_o(pixel_o),
	.line_o(line_o), .line_num_o(line_num_o), .field_o(field_o));
`default_nettype wire

/* File: tb/vtg_src_model.sv */
// Video source model: sync codes or sync pins, and a never-zero picture.
// Assumes the bench chooses embedded codes or pins and the field level.
`timescale 1ns/10ps
`default_nettype none
module vtg_src_model (
	// Clock and reset.
	input wire logic clk_i,
	input wire logic rst_i,
	// Controls from the bench.
	input wire logic emb_i,
	input wire logic field_i,
	// Toward the generator.
	output vtg_pkg::vtg_pins_t pins_o,
	output logic [7:0] pixel_o
);
	import vtg_pkg::*;
	logic [10:0] pix_r;
	logic field_r;
	always_ff @(posedge clk_i) begin
		if (rst_i || pix_r == PIX_PER_LINE - 11'h001) begin
			pix_r <= 11'h000;
		end else begin
			pix_r <= pix_r + 11'h001;
		end
	end
	// The field level changes only while line sync is low.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			field_r <= 1'b0;
		end else if (pix_r < HSYNC_PIX - 11'h001) begin
			field_r <= field_i;
		end
	end
	always_comb begin
		pins_o = 3'h7;
		pixel_o = {1'b1, pix_r[6:0]};
		if (!emb_i) begin
			pins_o.hsync_n = pix_r >= HSYNC_PIX;
			pins_o.vsync_field = field_r;
		end else if (pix_r < 11'h004 || (pix_r >= ACTIVE_START - 11'h004 && pix_r < ACTIVE_START)) begin
			pixel_o = 8'h00;
			if (pix_r[1:0] == 2'h0) begin
				pixel_o = 8'hff;
			end
			if (pix_r[1:0] == 2'h3) begin
				pixel_o = (pix_r < 11'h004) ? EAV_CODE : SAV_CODE;
			end
		end
	end
endmodule
`default_nettype wire

/* File: tb/video_timing_generator_tb_top.sv */
// Bench for the video timing generator: bus tasks and line checks.
// Assumes vtg_pkg, vtg_core and the source model are compiled first.
`timescale 1ns/10ps
`default_nettype none
module video_timing_generator_tb_top;
	import vtg_pkg::*;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic cyc_i = 1'b0;
	logic stb_i = 1'b0;
	logic we_i = 1'b0;
	logic [7:0] adr_i = 8'h00;
	logic [3:0] sel_i = 4'h0;
	logic [31:0] dat_i = 32'h0;
	logic [31:0] dat_o;
	logic [31:0] rd;
	logic ack_o;
	logic field_o;
	logic emb = 1'b1;
	logic fld = 1'b0;
	vtg_pins_t pins_i, pins_o, pins_oe_o;
	logic [7:0] pix_i, pixel_o;
	vtg_line_t line_o;
	logic [9:0] line_num_o;
	logic [7:0] ra [5] = '{ADR_MODE0, ADR_MODE3, ADR_TIMING0, ADR_SUBCAR, 8'h20};
	logic [31:0] re [5] = '{32'h4, 32'h0, 32'h0, SUBCAR_RST, 32'h0};
	int miscompares = 0;
	int n_checks = 0;
	always #50 clk_i = ~clk_i;
	vtg_core u_dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
		.adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
		.pins_i(pins_i), .pins_o(pins_o), .pins_oe_o(pins_oe_o), .pixel_bus_low_i(pix_i),
		.pixel_o(pixel_o), .line_o(line_o), .line_num_o(line_num_o), .field_o(field_o));
	vtg_src_model u_src (.clk_i(clk_i), .rst_i(rst_i), .emb_i(emb), .field_i(fld),
		.pins_o(pins_i), .pixel_o(pix_i));
	// ****************************************
	// Tasks
	// ****************************************
	task automatic conclude();
		if (miscompares == 0 && n_checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_checks++;
		if (g !== e) begin
			$display("ERROR %s expected %h seen %h", nm, e, g);
			miscompares++;
		end
	endtask
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk_i);
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		we_i <= w;
		adr_i <= a;
		dat_i <= d;
		sel_i <= 4'hf;
		do begin
			@(posedge clk_i);
			n++;
		end while (ack_o !== 1'b1 && n < 20);
		rd = dat_o;
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
		if (n >= 20) begin
			miscompares++;
			conclude();
		end
	endtask
	task automatic wait_line(input int l);
		int n;
		n = 0;
		while (line_num_o !== 10'(l) && n < 40000) begin
			@(posedge clk_i);
			n++;
		end
		if (n >= 40000) begin
			miscompares++;
			conclude();
		end
	endtask
	task automatic check_lines(input int lo, input int hi, input logic pt);
		logic vs, bk, bo, op;
		for (int l = lo; l <= hi; l++) begin
			wait_line(l);
			repeat (50) @(posedge clk_i);
			vs = l <= 9 || (l >= 264 && l <= 272);
			bk = l <= 21 || (l >= 262 && l <= 284) || l == 525;
			bo = l <= 6 || (l >= 261 && l <= 269) || l >= 523;
			op = (l >= 10 && l <= 21) || (l >= 274 && l <= 284);
			chk("vsync", 32'(vs), 32'(line_o.vsync));
			chk("burst", 32'(bo), 32'(line_o.burst_off));
			chk("field", 32'(l >= 263), 32'(field_o));
			chk("f pin", 32'(l >= 263), 32'(pins_o.vsync_field));
			chk("v pin", 32'(bk), 32'(pins_o.blank_n));
			chk("h pin", 32'h0, 32'(pins_o.hsync_n));
			chk("open", 32'(op), 32'(line_o.vbi_open));
			chk("dark", 32'(bk && !(op && pt)), 32'(pixel_o == 8'h00));
			if (!(op && pt)) begin
				chk("blank", 32'(bk), 32'(line_o.blank));
			end
		end
	endtask
	// ****************************************
	// Sequence
	// ****************************************
	initial begin
		int n;
		repeat (12) @(posedge clk_i);
		rst_i <= 1'b0;
		wb(1'b1, 8'h20, 32'hffffffff);
		foreach (ra[i]) begin
			wb(1'b0, ra[i], 32'h0);
			chk("reset value", re[i], rd);
		end
		emb <= 1'b0;
		wb(1'b1, ADR_TIMING0, 32'h1);
		wb(1'b0, ADR_TIMING0, 32'h0);
		chk("timing", 32'h1, rd);
		chk("master oe", 32'h7, 32'(pins_oe_o));
		check_lines(2, 24, 1'b0);
		wb(1'b1, ADR_MODE3, 32'h2);
		check_lines(261, 272, 1'b1);
		check_lines(274, 285, 1'b1);
		wb(1'b1, ADR_TIMING0, 32'h2);
		fld <= 1'b1;
		n = 0;
		while (line_num_o !== 10'h001 && n < 400) begin
			@(posedge clk_i);
			n++;
		end
		chk("frame start", 32'h1, 32'(line_num_o));
		chk("slave oe", 32'h0, 32'(pins_oe_o));
		wb(1'b0, ADR_STATUS, 32'h0);
		chk("status", 32'h00200001, rd);
		wb(1'b1, ADR_TIMING0, 32'h4);
		repeat (2) @(posedge clk_i);
		chk("hv slave oe", 32'h0, 32'(pins_oe_o));
		wb(1'b1, ADR_TIMING0, 32'h5);
		repeat (2) @(posedge clk_i);
		chk("hv master oe", 32'h7, 32'(pins_oe_o));
		conclude();
	end
endmodule
`default_nettype wire
